// ===== shared/synth_pkg.sv
package synth_pkg;

    // ------------------------------------------------------------
    // word lengths and field layout
    // ------------------------------------------------------------
    localparam int PTR_W     = 5;
    localparam int CNT_LEN   = 19;
    localparam int REF_W     = 14;
    localparam int SWALLOW_W = 7;
    localparam int MAIN_W    = 11;

    localparam logic [PTR_W-1:0] CNT_LEN_V = 5'h13;  // counter word, 19 bits
    localparam logic [PTR_W-1:0] REF_LEN_V = 5'h10;  // reference word, 16 bits

    localparam int SEL_CNT_POS = 18;  // selector of a counter word
    localparam int SEL_REF_POS = 15;  // selector of a reference word
    localparam int REF_LSB     = 1;
    localparam int PRE_POS     = 0;
    localparam int SWALLOW_LSB = 11;
    localparam int MAIN_LSB    = 0;

    // ------------------------------------------------------------
    // pin synchroniser lanes and reset values
    // ------------------------------------------------------------
    localparam int SYNC_W   = 5;
    localparam int SI_LOAD  = 0;
    localparam int SI_SENSE = 1;
    localparam int SI_PWR   = 2;
    localparam int SI_REFD  = 3;
    localparam int SI_PROGD = 4;

    localparam logic [SYNC_W-1:0]    SYNC_RST    = 5'h06;  // pulled-up pins read high
    localparam logic [REF_W-1:0]     REF_RST     = 14'h0000;
    localparam logic [SWALLOW_W-1:0] SWALLOW_RST = 7'h00;
    localparam logic [MAIN_W-1:0]    MAIN_RST    = 11'h000;
    localparam logic [PTR_W-1:0]     PTR_RST     = 5'h00;
    localparam logic [CNT_LEN-1:0]   WORD_RST    = 19'h00000;

    // ------------------------------------------------------------
    // phase detector states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PFD_IDLE = 3'b001,
        PFD_UP   = 3'b010,
        PFD_DN   = 3'b100
    } pfd_state_t;

    // ------------------------------------------------------------
    // gray code helpers for the bit pointer crossing
    // ------------------------------------------------------------
    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ===== rtl/serial_shifter.sv
`timescale 1ns/1ps
module serial_shifter #(
    parameter int WIDTH = synth_pkg::CNT_LEN
) (
    input  wire logic                       ser_clk,
    input  wire logic                       rst,
    input  wire logic                       ser_data,
    output logic [WIDTH-1:0]                shift_word,
    output logic [synth_pkg::PTR_W-1:0]     bit_ptr_gray
);
    import synth_pkg::*;

    logic             rst_s1;
    logic             rst_s2;
    logic [PTR_W-1:0] bit_count;
    logic [PTR_W-1:0] next_bit_count;
    logic [WIDTH-1:0] next_shift_word;
    logic [PTR_W-1:0] next_bit_ptr_gray;

    // ------------------------------------------------------------
    // reset brought onto the serial clock
    // ------------------------------------------------------------
    always_ff @(posedge ser_clk) begin
        rst_s1 <= rst;
        rst_s2 <= rst_s1;
    end

    // one bit per rising edge, msb first, plus a free running bit pointer
    always_comb begin
        next_shift_word   = {shift_word[WIDTH-2:0], ser_data};
        next_bit_count    = bit_count + 5'h01;
        next_bit_ptr_gray = bin2gray(next_bit_count);
    end

    // registers of the serial domain
    always_ff @(posedge ser_clk) begin
        if (rst_s2) begin
            shift_word   <= WORD_RST[WIDTH-1:0];
            bit_count    <= PTR_RST;
            bit_ptr_gray <= PTR_RST;
        end else begin
            shift_word   <= next_shift_word;
            bit_count    <= next_bit_count;
            bit_ptr_gray <= next_bit_ptr_gray;
        end
    end

endmodule

// ===== rtl/synth_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - each serial clock rising edge shifts exactly one data bit in
// - load strobe rising edge moves shifted word into counters and controls
// - phase sense low inverts phase detector polarity; undriven means normal
// - power down input is active low; high means normal operation
// - in power down the charge pump output is high impedance
// - lock indicator high while locked, with brief low pulses
// - loop bypass switch closed while load strobe is high, else open
// - programmed values kept through power down; invalid after reset until reprogrammed
// - first word bit selects reference word (1) or counter word (0)
// - prescaler bit low selects 128/129, high selects 64/65
// - reference word holds 14-bit divider; counter word 7-bit swallow, 11-bit main
module synth_ctrl (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          ser_clk,
    input  wire logic                          ser_data,
    input  wire logic                          load_strobe,
    input  wire logic                          phase_sense_select,
    input  wire logic                          power_down_n,
    input  wire logic                          ref_div_in,
    input  wire logic                          prog_div_in,
    output logic [synth_pkg::REF_W-1:0]        ref_count,
    output logic                               prescaler_64,
    output logic [synth_pkg::SWALLOW_W-1:0]    swallow_count,
    output logic [synth_pkg::MAIN_W-1:0]       main_count,
    output logic                               ref_loaded,
    output logic                               prog_loaded,
    output logic                               word_reject,
    output logic                               loop_bypass_switch,
    output logic                               pump_up,
    output logic                               pump_down,
    output logic                               pump_oe,
    output logic                               lock_indicator,
    output logic                               phase_monitor_out
);
    import synth_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [CNT_LEN-1:0]   shift_word;
    logic [PTR_W-1:0]     bit_ptr_gray;
    logic [SYNC_W-1:0]    pin_s1;
    logic [SYNC_W-1:0]    pin_s2;
    logic [CNT_LEN-1:0]   word_s1;
    logic [CNT_LEN-1:0]   word_s2;
    logic [PTR_W-1:0]     ptr_s1;
    logic [PTR_W-1:0]     ptr_s2;
    logic                 load_prev;
    logic                 refd_prev;
    logic                 progd_prev;
    logic [PTR_W-1:0]     last_ptr;
    logic [PTR_W-1:0]     next_last_ptr;
    logic [PTR_W-1:0]     word_len;
    logic                 load_rise;
    logic                 take_ref;
    logic                 take_cnt;
    logic [REF_W-1:0]     next_ref_count;
    logic                 next_prescaler_64;
    logic [SWALLOW_W-1:0] next_swallow_count;
    logic [MAIN_W-1:0]    next_main_count;
    logic                 next_ref_loaded;
    logic                 next_prog_loaded;
    logic                 next_word_reject;
    logic                 next_bypass;
    logic                 run;
    logic                 ref_rise;
    logic                 prog_rise;
    logic                 lead_rise;
    logic                 lag_rise;
    pfd_state_t           pfd_state;
    pfd_state_t           next_pfd_state;
    logic                 next_pump_up;
    logic                 next_pump_down;
    logic                 next_pump_oe;
    logic                 next_lock;
    logic                 next_monitor;

    // ------------------------------------------------------------
    // serial capture on the link clock
    // ------------------------------------------------------------
    serial_shifter #(
        .WIDTH (CNT_LEN)
    ) u_shifter (
        .ser_clk      (ser_clk),
        .rst          (rst),
        .ser_data     (ser_data),
        .shift_word   (shift_word),
        .bit_ptr_gray (bit_ptr_gray)
    );

    // ------------------------------------------------------------
    // two-flop synchronisers: pins, shifted word, gray bit pointer
    // ------------------------------------------------------------
    // word and pointer are quiet by the time the strobe edge is seen
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1  <= SYNC_RST;
            pin_s2  <= SYNC_RST;
            word_s1 <= WORD_RST;
            word_s2 <= WORD_RST;
            ptr_s1  <= PTR_RST;
            ptr_s2  <= PTR_RST;
        end else begin
            pin_s1  <= {prog_div_in, ref_div_in, power_down_n, phase_sense_select, load_strobe};
            pin_s2  <= pin_s1;
            word_s1 <= shift_word;
            word_s2 <= word_s1;
            ptr_s1  <= bit_ptr_gray;
            ptr_s2  <= ptr_s1;
        end
    end

    // ------------------------------------------------------------
    // word load and target decode
    // ------------------------------------------------------------
    // length of the word is the pointer distance since the last load
    always_comb begin
        load_rise     = pin_s2[SI_LOAD] & ~load_prev;
        word_len      = gray2bin(ptr_s2) - last_ptr;
        take_ref      = load_rise && word_len == REF_LEN_V && word_s2[SEL_REF_POS];
        take_cnt      = load_rise && word_len == CNT_LEN_V && !word_s2[SEL_CNT_POS];
        next_last_ptr = load_rise ? gray2bin(ptr_s2) : last_ptr;
        next_ref_count     = ref_count;
        next_prescaler_64  = prescaler_64;
        next_swallow_count = swallow_count;
        next_main_count    = main_count;
        next_ref_loaded    = ref_loaded;
        next_prog_loaded   = prog_loaded;
        if (take_ref) begin
            next_ref_count    = word_s2[REF_LSB +: REF_W];
            next_prescaler_64 = word_s2[PRE_POS];
            next_ref_loaded   = 1'b1;
        end
        if (take_cnt) begin
            next_swallow_count = word_s2[SWALLOW_LSB +: SWALLOW_W];
            next_main_count    = word_s2[MAIN_LSB +: MAIN_W];
            next_prog_loaded   = 1'b1;
        end
        next_word_reject = load_rise & ~take_ref & ~take_cnt;
        next_bypass      = pin_s2[SI_LOAD];
    end

    // load registers; nothing programmed survives reset
    always_ff @(posedge clk) begin
        if (rst) begin
            load_prev          <= 1'b0;
            last_ptr           <= PTR_RST;
            ref_count          <= REF_RST;
            prescaler_64       <= 1'b0;
            swallow_count      <= SWALLOW_RST;
            main_count         <= MAIN_RST;
            ref_loaded         <= 1'b0;
            prog_loaded        <= 1'b0;
            word_reject        <= 1'b0;
            loop_bypass_switch <= 1'b0;
        end else begin
            load_prev          <= pin_s2[SI_LOAD];
            last_ptr           <= next_last_ptr;
            ref_count          <= next_ref_count;
            prescaler_64       <= next_prescaler_64;
            swallow_count      <= next_swallow_count;
            main_count         <= next_main_count;
            ref_loaded         <= next_ref_loaded;
            prog_loaded        <= next_prog_loaded;
            word_reject        <= next_word_reject;
            loop_bypass_switch <= next_bypass;
        end
    end

    // ------------------------------------------------------------
    // phase detector, charge pump drive and lock indicator
    // ------------------------------------------------------------
    // sense high: reference leading pumps up; sense low swaps the roles
    always_comb begin
        run       = pin_s2[SI_PWR] & ref_loaded & prog_loaded;
        ref_rise  = pin_s2[SI_REFD] & ~refd_prev;
        prog_rise = pin_s2[SI_PROGD] & ~progd_prev;
        lead_rise = pin_s2[SI_SENSE] ? ref_rise : prog_rise;
        lag_rise  = pin_s2[SI_SENSE] ? prog_rise : ref_rise;
        case (pfd_state)
            PFD_IDLE: begin
                if (lead_rise && !lag_rise) begin
                    next_pfd_state = PFD_UP;
                end else if (lag_rise && !lead_rise) begin
                    next_pfd_state = PFD_DN;
                end else begin
                    next_pfd_state = PFD_IDLE;
                end
            end
            PFD_UP: begin
                next_pfd_state = lag_rise ? PFD_IDLE : PFD_UP;
            end
            PFD_DN: begin
                next_pfd_state = lead_rise ? PFD_IDLE : PFD_DN;
            end
            default: begin
                next_pfd_state = PFD_IDLE;
            end
        endcase
        if (!run) begin
            next_pfd_state = PFD_IDLE;
        end
        next_pump_up   = next_pfd_state == PFD_UP;
        next_pump_down = next_pfd_state == PFD_DN;
        next_pump_oe   = run;
        next_lock      = run && next_pfd_state == PFD_IDLE;
        next_monitor   = pin_s2[SI_SENSE] ? pin_s2[SI_REFD] : pin_s2[SI_PROGD];
    end

    // detector state and pump pins
    always_ff @(posedge clk) begin
        if (rst) begin
            refd_prev         <= 1'b0;
            progd_prev        <= 1'b0;
            pfd_state         <= PFD_IDLE;
            pump_up           <= 1'b0;
            pump_down         <= 1'b0;
            pump_oe           <= 1'b0;
            lock_indicator    <= 1'b0;
            phase_monitor_out <= 1'b0;
        end else begin
            refd_prev         <= pin_s2[SI_REFD];
            progd_prev        <= pin_s2[SI_PROGD];
            pfd_state         <= next_pfd_state;
            pump_up           <= next_pump_up;
            pump_down         <= next_pump_down;
            pump_oe           <= next_pump_oe;
            lock_indicator    <= next_lock;
            phase_monitor_out <= next_monitor;
        end
    end

endmodule

// ===== test/synth_ctrl_asserts.sv
`timescale 1ns/1ps
module synth_ctrl_asserts (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        load_strobe,
    input wire logic                        phase_sense_select,
    input wire logic                        power_down_n,
    input wire logic                        ref_div_in,
    input wire logic                        prog_div_in,
    input wire logic [synth_pkg::REF_W-1:0] ref_count,
    input wire logic [synth_pkg::MAIN_W-1:0] main_count,
    input wire logic                        ref_loaded,
    input wire logic                        prog_loaded,
    input wire logic                        word_reject,
    input wire logic                        loop_bypass_switch,
    input wire logic                        pump_up,
    input wire logic                        pump_down,
    input wire logic                        pump_oe,
    input wire logic                        lock_indicator,
    input wire logic                        phase_monitor_out
);
    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_bypass_closed: assert property (load_strobe [*5] |-> loop_bypass_switch)
        else $error("bypass open while strobe held high");
    a_bypass_open: assert property (!load_strobe [*5] |-> !loop_bypass_switch)
        else $error("bypass closed while strobe held low");
    a_pd_tristate: assert property (!power_down_n [*4] |-> !(pump_oe || pump_up || pump_down))
        else $error("pump driven in power down");
    a_oe_needs_words: assert property (pump_oe |-> ref_loaded && prog_loaded)
        else $error("pump driven before both words loaded");
    a_pump_unlocks: assert property ((pump_up || pump_down) |-> pump_oe && !lock_indicator)
        else $error("pumping without enable or with lock high");
    a_reject_single: assert property (word_reject |=> !word_reject)
        else $error("reject longer than one cycle");
    a_load_on_strobe: assert property (($changed(ref_count) || $changed(main_count)) |-> $past(load_strobe, 2))
        else $error("counters changed without strobe");
    a_monitor_ref: assert property ((phase_sense_select && $stable(ref_div_in)) [*5]
        |-> phase_monitor_out == ref_div_in)
        else $error("monitor not showing reference divider");
    a_monitor_prog: assert property ((!phase_sense_select && $stable(prog_div_in)) [*5]
        |-> phase_monitor_out == prog_div_in)
        else $error("monitor not showing programmable divider");
    a_unloaded_no_lock: assert property (!prog_loaded |-> !lock_indicator)
        else $error("lock high before counter word loaded");
endmodule

bind synth_ctrl synth_ctrl_asserts synth_ctrl_asserts_inst (.clk(clk), .rst(rst), .load_strobe(load_strobe),
    .phase_sense_select(phase_sense_select), .power_down_n(power_down_n), .ref_div_in(ref_div_in),
    .prog_div_in(prog_div_in), .ref_count(ref_count), .main_count(main_count), .ref_loaded(ref_loaded),
    .prog_loaded(prog_loaded), .word_reject(word_reject), .loop_bypass_switch(loop_bypass_switch),
    .pump_up(pump_up), .pump_down(pump_down), .pump_oe(pump_oe), .lock_indicator(lock_indicator),
    .phase_monitor_out(phase_monitor_out));

// ===== test/ser_ctrl_model.sv
`timescale 1ns/1ps
module ser_ctrl_model (
    output logic ser_clk,
    output logic ser_data,
    output logic load_strobe
);
    // ------------------------------------------------------------
    // three-wire controller
    // ------------------------------------------------------------
    initial begin
        ser_clk = 1'h0;
        ser_data = 1'h0;
        load_strobe = 1'h0;
    end
    // one 15 ns period per bit, data set up before the rising edge
    task automatic tick(input logic b);
        ser_data = b;
        #7.5 ser_clk = 1'h1;
        #7.5 ser_clk = 1'h0;
    endtask
    // msb first, selector bit leads; line then shows the inverse
    task automatic send(input logic [18:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            tick(w[i]);
        end
        ser_data = ~ser_data;
    endtask
    // free clocks with toggling data, used around reset
    task automatic idle(input int n);
        repeat (n) tick(~ser_data);
    endtask
    // strobe moved only once the whole word is in
    task automatic strobe(input logic v);
        load_strobe = v;
    endtask
endmodule

// ===== test/synth_ctrl_tb_top.sv
`timescale 1ns/1ps
module synth_ctrl_tb_top;
    import synth_pkg::*;
    logic                 clk = 1'h0, rst = 1'h1, sense = 1'h1, pwr_n = 1'h1, refd = 1'h0, progd = 1'h0;
    logic                 ser_clk, ser_data, load_strobe, pre, rl, pl, rej, byp, up, dn, oe, lock, mon;
    logic                 rej_seen = 1'h0;
    logic [REF_W-1:0]     ref_count;
    logic [SWALLOW_W-1:0] swallow_count;
    logic [MAIN_W-1:0]    main_count;
    int                   fails = 0, checks_done = 0, cycles = 0;

    always #50 clk = ~clk;

    ser_ctrl_model ser_ctrl_model_inst (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));
    synth_ctrl synth_ctrl_inst (.clk(clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
        .load_strobe(load_strobe), .phase_sense_select(sense), .power_down_n(pwr_n), .ref_div_in(refd),
        .prog_div_in(progd), .ref_count(ref_count), .prescaler_64(pre), .swallow_count(swallow_count),
        .main_count(main_count), .ref_loaded(rl), .prog_loaded(pl), .word_reject(rej),
        .loop_bypass_switch(byp), .pump_up(up), .pump_down(dn), .pump_oe(oe), .lock_indicator(lock),
        .phase_monitor_out(mon));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // watchdog and reject pulse catcher
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rej === 1'h1) rej_seen <= 1'h1;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // serial clock keeps running through reset
    task automatic do_reset;
        @(negedge clk) rst = 1'h1;
        fork
            begin repeat (5) @(negedge clk); rst = 1'h0; end
            ser_ctrl_model_inst.idle(50);
        join
        // idle ends on a serial clock falling edge; step to a clk falling edge before anyone samples
        @(negedge clk);
    endtask
    // shift a word, wait the quiet gap, pulse the strobe
    task automatic load(input logic [18:0] w, input int n);
        ser_ctrl_model_inst.send(w, n);
        repeat (4) @(negedge clk);
        rej_seen = 1'h0;
        ser_ctrl_model_inst.strobe(1'h1);
        repeat (6) @(negedge clk);
        chk(byp, 1'h1);
        ser_ctrl_model_inst.strobe(1'h0);
        repeat (6) @(negedge clk);
        chk(byp, 1'h0);
    endtask
    // one divider edge, then the other
    task automatic pair(input logic ref_first, input logic eu, input logic ed);
        if (ref_first) refd = 1'h1; else progd = 1'h1;
        repeat (5) @(negedge clk);
        chk({up, dn, oe, lock}, {eu, ed, 1'h1, 1'h0});
        refd = 1'h1;
        progd = 1'h1;
        repeat (5) @(negedge clk);
        chk({up, dn, oe, lock}, 4'h3);
        refd = 1'h0;
        progd = 1'h0;
        repeat (5) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        chk({rl, pl, oe, lock, byp}, 5'h00);
        load(19'h00000, 1);
        load({3'h0, 1'h1, 14'h2a5c, 1'h1}, 16);
        chk({ref_count, pre, rl}, {14'h2a5c, 1'h1, 1'h1});
        load({3'h0, 1'h1, 14'h0013, 1'h0}, 16);
        chk({ref_count, pre, pl, oe}, {14'h0013, 1'h0, 1'h0, 1'h0});
        progd = 1'h1;
        sense = 1'h0;
        repeat (6) @(negedge clk);
        chk(mon, 1'h1);
        sense = 1'h1;
        repeat (6) @(negedge clk);
        chk(mon, 1'h0);
        progd = 1'h0;
        load({1'h0, 7'h5a, 11'h3c7}, 19);
        chk({swallow_count, main_count, pl, rej_seen}, {7'h5a, 11'h3c7, 1'h1, 1'h0});
        chk({oe, lock}, 2'h3);
        load(19'h00155, 18);
        chk({rej_seen, swallow_count, main_count}, {1'h1, 7'h5a, 11'h3c7});
        load({1'h1, 7'h7f, 11'h7ff}, 19);
        chk({rej_seen, swallow_count, ref_count}, {1'h1, 7'h5a, 14'h0013});
        load({3'h0, 1'h0, 14'h3fff, 1'h1}, 16);
        chk({rej_seen, ref_count, pre}, {1'h1, 14'h0013, 1'h0});
        pair(1'h1, 1'h1, 1'h0);
        pwr_n = 1'h0;
        repeat (5) @(negedge clk);
        refd = 1'h1;
        repeat (5) @(negedge clk);
        chk({up, dn, oe}, 3'h0);
        refd = 1'h0;
        pwr_n = 1'h1;
        repeat (5) @(negedge clk);
        pair(1'h0, 1'h0, 1'h1);
        sense = 1'h0;
        repeat (5) @(negedge clk);
        pair(1'h1, 1'h0, 1'h1);
        pair(1'h0, 1'h1, 1'h0);
        do_reset();
        chk({ref_count, rl, pl, oe, lock}, 18'h0);
        report_and_stop();
    end
endmodule
